// *** design/avss_pkg.sv ***
/*
  package for the auxiliary video source select link: widths, enable
  reset values and the dot clock divider count.
  assumes: both ends run on one 200 MHz clock, link pins sampled.
*/
package avss_pkg;
  // -------------------------------------------------------------------
  // widths and reset values
  // -------------------------------------------------------------------
  localparam int          PIX_W         = 8;
  localparam logic        EN_N_RESET    = 1'b1;
  localparam logic [7:0]  PIX_RESET     = 8'h00;
  localparam logic [2:0]  SYNC_RESET    = 3'h7;
  // -------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------
  localparam int          MCLK_PERIOD_NS = 5;
  localparam int          DOT_PERIOD_NS  = 40;
  localparam int          DOT_HALF_CYC   = DOT_PERIOD_NS / (2 * MCLK_PERIOD_NS);
  localparam int          SYNC_STAGES    = 3;
endpackage

// *** design/avss_link_if.sv ***
/*
  link between system-board video end and adapter end.
  assumes: the bench resolves open-drain/tristate levels from the enables;
  enables default high (pull-up) when nobody pulls them low.
*/
`timescale 1ns/10ps
interface avss_link_if;
  logic [7:0] brd_pix;
  logic       brd_pix_oe_n;
  logic [7:0] ad_pix;
  logic       ad_pix_oe_n;
  logic [2:0] brd_sync;
  logic       brd_sync_oe_n;
  logic [2:0] ad_sync;
  logic       ad_sync_oe_n;
  logic       brd_dot_clock;
  logic       brd_dot_clock_oe_n;
  logic       ad_dot_clock;
  logic       ad_dot_clock_oe_n;
  logic       ext_sync_en_n;
  logic       ext_pixel_en_n;
  logic       ext_dotclk_en_n;
  logic       ad_sync_en_pull;
  logic       ad_pixel_en_pull;
  logic       ad_dotclk_en_pull;
  logic [7:0] pixel_addr;
  logic [2:0] sync_bus;
  logic       dot_clock;
  modport board (
    output brd_pix, brd_pix_oe_n, brd_sync, brd_sync_oe_n, brd_dot_clock, brd_dot_clock_oe_n,
    input  ext_sync_en_n, ext_pixel_en_n, ext_dotclk_en_n, pixel_addr, sync_bus,
    input  dot_clock
  );
  modport adapter (
    output ad_pix, ad_pix_oe_n, ad_sync, ad_sync_oe_n, ad_dot_clock, ad_dot_clock_oe_n,
    output ad_sync_en_pull, ad_pixel_en_pull, ad_dotclk_en_pull,
    input  sync_bus, dot_clock
  );
endinterface

// *** design/avss_adapter.sv ***
/*
  adapter end: claims source groups by pulling enables low, drives the
  claimed groups, makes its own dot clock by divider.
  assumes: user presents next pixel word and sync levels on its ports.
*/
`timescale 1ns/10ps
module avss_adapter
  import avss_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_resetn,
  input  wire logic       i_claim_sync,
  input  wire logic       i_claim_pixel,
  input  wire logic       i_claim_dotclk,
  input  wire logic [7:0] i_pixel,
  input  wire logic [2:0] i_sync,
  output logic            o_claim_state_sync,
  output logic            o_claim_state_pixel,
  output logic            o_claim_state_dotclk,
  avss_link_if.adapter    link
);
  // -------------------------------------------------------------------
  // claim updates only while blanked
  // -------------------------------------------------------------------
  logic [2:0] claim_ff, nxt_claim;
  logic [7:0] pix_ff, nxt_pix;
  logic [2:0] sync_ff, nxt_sync;
  logic [7:0] div_ff, nxt_div;
  logic       dot_clock_ff, nxt_dot_clock;
  logic [2:0] bl_sync_ff;
  logic       blank_now;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      bl_sync_ff <= 3'h7;
    end else begin
      bl_sync_ff <= {bl_sync_ff[1:0], link.sync_bus[0]};
    end
  end
  // blank is active low; 2nd and 3rd stage must agree
  assign blank_now = !bl_sync_ff[1] && !bl_sync_ff[2];

  always_comb begin
    nxt_claim = claim_ff;
    if (blank_now) begin
      // clocks never claimed without pixels change in blank
      nxt_claim = {i_claim_dotclk && i_claim_pixel, i_claim_pixel, i_claim_sync};
    end
    nxt_div  = div_ff + 8'h01;
    nxt_dot_clock = dot_clock_ff;
    nxt_pix  = pix_ff;
    nxt_sync = i_sync;
    if (div_ff == 8'(DOT_HALF_CYC - 1)) begin
      nxt_div  = 8'h00;
      nxt_dot_clock = !dot_clock_ff;
      // change pixel on falling edge, stable at rising
      if (dot_clock_ff) begin
        nxt_pix = i_pixel;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      claim_ff <= 3'h0;
      div_ff   <= 8'h00;
      dot_clock_ff  <= 1'b0;
      pix_ff   <= PIX_RESET;
      sync_ff  <= SYNC_RESET;
    end else begin
      claim_ff <= nxt_claim;
      div_ff   <= nxt_div;
      dot_clock_ff  <= nxt_dot_clock;
      pix_ff   <= nxt_pix;
      sync_ff  <= nxt_sync;
    end
  end

  // -------------------------------------------------------------------
  // link drive
  // -------------------------------------------------------------------
  assign link.ad_sync_en_pull   = claim_ff[0];
  assign link.ad_pixel_en_pull  = claim_ff[1];
  assign link.ad_dotclk_en_pull = claim_ff[2];
  assign link.ad_sync           = sync_ff;
  assign link.ad_sync_oe_n      = !claim_ff[0];
  assign link.ad_pix            = pix_ff;
  assign link.ad_pix_oe_n       = !claim_ff[1];
  assign link.ad_dot_clock           = dot_clock_ff;
  assign link.ad_dot_clock_oe_n      = !claim_ff[2];
  assign o_claim_state_sync     = claim_ff[0];
  assign o_claim_state_pixel    = claim_ff[1];
  assign o_claim_state_dotclk   = claim_ff[2];
endmodule

// *** design/avss_board.sv ***
/*
  system-board video end: drives sync, blank, pixel bits and dot clock
  unless the adapter pulls the matching enable low; holds the palette
  capture stage that latches pixel bits on dot clock rising edges.
  assumes: link pins are asynchronous to i_mclk and pass 3 flip-flops.
*/
// Summary of operation
// - palette captures pixel bits on dot rising edge
// - selected source drives eight-bit pixel word
// - blank low forces colour output to zero
// - sync enable high: board drives sync group
// - pixel enable high: board drives pixel bits
// - clock enable high: board makes dot clock
// - adapter clock implies adapter pixel data
// - enables default high via pull-up
// - board timing follows adapter clock when external
`timescale 1ns/10ps
module avss_board
  import avss_pkg::*;
#(
  parameter int DIV_HALF = DOT_HALF_CYC
)(
  input  wire logic       i_mclk,
  input  wire logic       i_resetn,
  input  wire logic [7:0] i_pixel,
  input  wire logic [2:0] i_sync,
  output logic [7:0]      o_colour_index,
  output logic            o_colour_on,
  output logic            o_dot_edge,
  avss_link_if.board      link
);
  // -------------------------------------------------------------------
  // pin synchronisers, three stages each
  // -------------------------------------------------------------------
  // a change counts once stages 2 and 3 agree, so a bit caught
  // mid-transition never reaches the capture logic
  // limitation: a dot clock phase shorter than two mclk cycles is lost
  localparam int SW = 3 + 8 + 3 + 1;
  logic [SW-1:0] pins;
  logic [SW-1:0] s1_ff, nxt_s1;
  logic [SW-1:0] s2_ff, nxt_s2;
  logic [SW-1:0] s3_ff, nxt_s3;
  logic [SW-1:0] stable_ff, nxt_stable;
  logic [SW-1:0] stable;

  assign pins = {link.ext_sync_en_n, link.ext_pixel_en_n, link.ext_dotclk_en_n,
                 link.pixel_addr, link.sync_bus, link.dot_clock};

  genvar g;
  generate
    for (g = 0; g < SW; g++) begin : g_agree
      assign nxt_stable[g] = (s2_ff[g] == s3_ff[g]) ? s3_ff[g] : stable_ff[g];
    end
  endgenerate

  always_comb begin
    nxt_s1 = pins;
    nxt_s2 = s1_ff;
    nxt_s3 = s2_ff;
  end

  // reset to all ones: enables read high, the board owns every group
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      s1_ff     <= {SW{1'b1}};
      s2_ff     <= {SW{1'b1}};
      s3_ff     <= {SW{1'b1}};
      stable_ff <= {SW{1'b1}};
    end else begin
      s1_ff     <= nxt_s1;
      s2_ff     <= nxt_s2;
      s3_ff     <= nxt_s3;
      stable_ff <= nxt_stable;
    end
  end
  assign stable = stable_ff;

  // latency: a pin change shows here 4 to 5 cycles later
  logic       en_sync_n, en_pix_n, en_dot_clock_n;
  logic [7:0] pix_s;
  logic       blank_n_s;
  logic       dot_clock_s;
  assign en_sync_n = stable[14];
  assign en_pix_n  = stable[13];
  assign en_dot_clock_n = stable[12];
  assign pix_s     = stable[11:4];
  assign blank_n_s = stable[1];
  assign dot_clock_s    = stable[0];

  // one decode for the pixel and clock groups: own value while the enable reads
  // high, the synchronised pin otherwise
  function automatic logic [7:0] pick_source(input logic       en_n,
                                             input logic [7:0] own,
                                             input logic [7:0] ext);
    pick_source = en_n ? own : ext;
  endfunction

  // -------------------------------------------------------------------
  // dot clock divider and source choice
  // -------------------------------------------------------------------
  logic [7:0] div_ff, nxt_div;
  logic       dot_clock_ff, nxt_dot_clock;
  logic       dprev_ff, nxt_dprev;
  logic [7:0] clk_pick;
  logic       clk_src;
  logic       rise;

  // external clock taken from the synchronised pin
  assign clk_pick = pick_source(en_dot_clock_n, {7'h00, dot_clock_ff}, {7'h00, dot_clock_s});
  assign clk_src  = clk_pick[0];
  assign rise     = clk_src && !dprev_ff;

  // divider keeps running while the adapter owns the clock, so a handback
  // needs no restart; the cost is one idle toggler
  // rise is seen in the same cycle the source goes high, on top of the
  // synchroniser delay when the clock is external
  always_comb begin
    nxt_div  = div_ff + 8'h01;
    nxt_dot_clock = dot_clock_ff;
    if (div_ff == 8'(DIV_HALF - 1)) begin
      nxt_div  = 8'h00;
      nxt_dot_clock = !dot_clock_ff;
    end
    nxt_dprev = clk_src;
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      div_ff   <= 8'h00;
      dot_clock_ff  <= 1'b0;
      dprev_ff <= 1'b0;
    end else begin
      div_ff   <= nxt_div;
      dot_clock_ff  <= nxt_dot_clock;
      dprev_ff <= nxt_dprev;
    end
  end

  // -------------------------------------------------------------------
  // board drive registers and palette capture
  // -------------------------------------------------------------------
  logic [7:0] bpix_ff, nxt_bpix;
  logic [2:0] bsync_ff, nxt_bsync;
  logic [7:0] cap_ff, nxt_cap;
  logic       on_ff, nxt_on;
  logic       edge_ff, nxt_edge;
  logic [7:0] colour_ff, nxt_colour;
  logic [7:0] sel_pix;

  // pixel word from whichever side owns the lines
  assign sel_pix = pick_source(en_pix_n, bpix_ff, pix_s);

  // own word taken from the register while the board owns the lines,
  // which saves the synchroniser delay on the board path
  always_comb begin
    nxt_bpix  = bpix_ff;
    nxt_bsync = i_sync;
    nxt_cap   = cap_ff;
    nxt_on    = on_ff;
    nxt_edge  = rise;
    // new board word right after a rising edge, stable by the next
    if (rise) begin
      nxt_bpix = i_pixel;
      nxt_cap  = sel_pix;
      nxt_on   = blank_n_s;
    end
    if (!blank_n_s) begin
      nxt_on = 1'b0;
    end
    // colour forced to zero while blanked
    nxt_colour = nxt_on ? nxt_cap : 8'h00;
  end

  // edge pulse lasts one mclk per detected rise
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      bpix_ff   <= PIX_RESET;
      bsync_ff  <= SYNC_RESET;
      cap_ff    <= PIX_RESET;
      on_ff     <= 1'b0;
      edge_ff   <= 1'b0;
      colour_ff <= PIX_RESET;
    end else begin
      bpix_ff   <= nxt_bpix;
      bsync_ff  <= nxt_bsync;
      cap_ff    <= nxt_cap;
      on_ff     <= nxt_on;
      edge_ff   <= nxt_edge;
      colour_ff <= nxt_colour;
    end
  end

  // -------------------------------------------------------------------
  // outputs and link drive
  // -------------------------------------------------------------------
  // outputs come straight from flip-flops, no glitches at the pins
  assign o_colour_index = colour_ff;
  assign o_colour_on    = on_ff;
  assign o_dot_edge     = edge_ff;

  // release groups the adapter claimed
  // a claim only moves while blanked, so a release never cuts a pixel
  assign link.brd_sync      = bsync_ff;
  assign link.brd_sync_oe_n = !en_sync_n;
  assign link.brd_pix       = bpix_ff;
  assign link.brd_pix_oe_n  = !en_pix_n;
  assign link.brd_dot_clock      = dot_clock_ff;
  assign link.brd_dot_clock_oe_n = !en_dot_clock_n;
endmodule

// *** tb/avss_chk.sv ***
/*
  link checker: ownership of each signal group versus its enable,
  board dot clock shape, adapter clock without adapter pixels.
  assumes: sits beside the link, board divider half count left at 4.
*/
`timescale 1ns/10ps
module avss_chk (
  input  wire logic       i_mclk,
  input  wire logic       i_resetn,
  input  wire logic       brd_pix_oe_n,
  input  wire logic       brd_sync_oe_n,
  input  wire logic       brd_dot_clock_oe_n,
  input  wire logic       brd_dot_clock,
  input  wire logic       ad_pix_oe_n,
  input  wire logic       ad_dot_clock_oe_n,
  input  wire logic       ext_sync_en_n,
  input  wire logic       ext_pixel_en_n,
  input  wire logic       ext_dotclk_en_n
);
  // -------------------------------------------------------------------
  // properties
  // -------------------------------------------------------------------
  // 8 cycles covers the 4-5 cycle handover through the synchronisers
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  sync_own_a: assert property (ext_sync_en_n [*8] |-> !brd_sync_oe_n)
    else $error("board not driving sync group");
  sync_release_a: assert property (!ext_sync_en_n [*8] |-> brd_sync_oe_n)
    else $error("board still drives sync group");
  pixel_own_a: assert property (ext_pixel_en_n [*8] |-> !brd_pix_oe_n)
    else $error("board not driving pixel bits");
  pixel_release_a: assert property (!ext_pixel_en_n [*8] |-> brd_pix_oe_n)
    else $error("board buffer still on for pixels");
  clock_own_a: assert property (ext_dotclk_en_n [*8] |-> !brd_dot_clock_oe_n)
    else $error("board not driving dot clock");
  clock_release_a: assert property (!ext_dotclk_en_n [*8] |-> brd_dot_clock_oe_n)
    else $error("board still drives dot clock");
  clock_needs_pixel_a: assert property (!ad_dot_clock_oe_n |-> !ad_pix_oe_n)
    else $error("adapter clock without adapter pixels");
  dot_half_period_a: assert property ($rose(brd_dot_clock) |-> brd_dot_clock [*4] ##1 !brd_dot_clock)
    else $error("board dot clock high phase wrong");
endmodule

// *** tb/aux_video_source_select_tb.sv ***
/*
  testbench: board and adapter ends face each other on one link.
  assumes: bench resolves enables from pulls and wires from oe_n.
*/
`timescale 1ns/10ps
module aux_video_source_select_tb;
  import avss_pkg::*;
  logic       i_mclk;
  logic       i_resetn;
  logic [2:0] claim;
  logic [2:0] state;
  logic [2:0] brd_sync;
  logic [2:0] ad_sync;
  logic [7:0] ad_pixel;
  logic [7:0] brd_pixel;
  logic [7:0] colour;
  logic       colour_on;
  logic       dot_edge;
  int         mismatches;
  int         checked;
  avss_link_if link ();
  // -------------------------------------------------------------------
  // wire resolution, pull-ups on the enables
  // -------------------------------------------------------------------
  assign link.ext_sync_en_n   = !link.ad_sync_en_pull;
  assign link.ext_pixel_en_n  = !link.ad_pixel_en_pull;
  assign link.ext_dotclk_en_n = !link.ad_dotclk_en_pull;
  assign link.pixel_addr = !link.ad_pix_oe_n ? link.ad_pix : link.brd_pix;
  assign link.sync_bus   = !link.ad_sync_oe_n ? link.ad_sync : link.brd_sync;
  assign link.dot_clock  = !link.ad_dot_clock_oe_n ? link.ad_dot_clock : link.brd_dot_clock;
  avss_board avss_board_inst (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_pixel(brd_pixel),
    .i_sync(brd_sync), .o_colour_index(colour), .o_colour_on(colour_on),
    .o_dot_edge(dot_edge), .link(link));
  avss_adapter avss_adapter_inst (.i_mclk(i_mclk), .i_resetn(i_resetn),
    .i_claim_sync(claim[0]), .i_claim_pixel(claim[1]), .i_claim_dotclk(claim[2]),
    .i_pixel(ad_pixel), .i_sync(ad_sync), .o_claim_state_sync(state[0]),
    .o_claim_state_pixel(state[1]), .o_claim_state_dotclk(state[2]), .link(link));
  avss_chk avss_chk_inst (.i_mclk(i_mclk), .i_resetn(i_resetn),
    .brd_pix_oe_n(link.brd_pix_oe_n), .brd_sync_oe_n(link.brd_sync_oe_n),
    .brd_dot_clock_oe_n(link.brd_dot_clock_oe_n), .brd_dot_clock(link.brd_dot_clock),
    .ad_pix_oe_n(link.ad_pix_oe_n), .ad_dot_clock_oe_n(link.ad_dot_clock_oe_n),
    .ext_sync_en_n(link.ext_sync_en_n), .ext_pixel_en_n(link.ext_pixel_en_n),
    .ext_dotclk_en_n(link.ext_dotclk_en_n));
  // -------------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(input logic [2:0] c, input logic [2:0] bs, input logic [2:0] as,
                      input logic [7:0] ap);
    int n;
    @(posedge i_mclk);
    claim <= c;
    brd_sync <= bs;
    ad_sync <= as;
    ad_pixel <= ap;
    // synchronisers need about 4 cycles, then one whole dot period
    repeat (12) @(negedge i_mclk);
    n = 0;
    while (dot_edge !== 1'b1 && n < 40) begin
      @(negedge i_mclk);
      n++;
    end
    chk("dot edge", 8'h01, {7'h00, dot_edge});
    @(negedge i_mclk);
  endtask
  task automatic chk_owner(input logic [2:0] st);
    chk("claims", {5'h00, st}, {5'h00, state});
    chk("enables", {5'h00, ~st}, {5'h00, link.ext_dotclk_en_n, link.ext_pixel_en_n,
      link.ext_sync_en_n});
    chk("board oe", {5'h00, st}, {5'h00, link.brd_dot_clock_oe_n, link.brd_pix_oe_n,
      link.brd_sync_oe_n});
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // -------------------------------------------------------------------
  // clock, watchdog, tests
  // -------------------------------------------------------------------
  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  initial begin
    #50000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    i_resetn = 1'b0;
    claim = 3'h0;
    brd_sync = 3'h7;
    ad_sync = 3'h6;
    ad_pixel = 8'h00;
    brd_pixel = 8'h3C;
    mismatches = 0;
    checked = 0;
    repeat (8) @(posedge i_mclk);
    i_resetn <= 1'b1;
    step(3'h2, 3'h7, 3'h6, 8'h5A);
    chk_owner(3'h0);
    chk("colour", 8'h3C, colour);
    chk("colour on", 8'h01, {7'h00, colour_on});
    $display("done: board source, claim outside blanking");
    step(3'h4, 3'h6, 3'h6, 8'h5A);
    chk_owner(3'h0);
    chk("blanked colour", 8'h00, colour);
    chk("colour on", 8'h00, {7'h00, colour_on});
    $display("done: blanking, lone clock claim");
    step(3'h7, 3'h6, 3'h6, 8'h5A);
    chk_owner(3'h7);
    step(3'h7, 3'h6, 3'h7, 8'hA5);
    chk("adapter colour", 8'hA5, colour);
    $display("done: adapter source");
    step(3'h0, 3'h6, 3'h6, 8'hA5);
    chk_owner(3'h0);
    @(posedge i_mclk);
    brd_pixel <= 8'hC3;
    step(3'h0, 3'h7, 3'h6, 8'hA5);
    chk("colour back", 8'hC3, colour);
    $display("done: release to board");
    tally_and_finish();
  end
endmodule
